// *** dv/etw_mem_model.sv ***
`timescale 1ns/10ps
module etw_mem_model
(
  input  wire        clk,
  input  wire [15:0] ad_out,
  input  wire [4:0]  addr_hi,
  input  wire        addr_le,
  input  wire        wl_n,
  input  wire        wh_n,
  input  wire        ub_n,
  input  wire        lb_n,
  input  wire        ba,
  input  wire        re_n,
  output reg  [15:0] rd_bus,
  output reg  [20:0] w_addr,
  output reg  [15:0] w_data,
  output reg  [4:0]  w_kind,
  output reg  [7:0]  w_cnt
);
  reg [20:0] a_r;
  reg        idle_r;
  initial
  begin
    rd_bus = 16'h0000;
    w_cnt = 8'h00;
    idle_r = 1'b1;
  end
  always @(posedge clk)
  begin
    if (addr_le)
      a_r <= {addr_hi, ad_out};
    if (!(wl_n & wh_n))
    begin
      w_addr <= a_r;
      w_data <= ad_out;
      w_kind <= {wh_n, wl_n, ub_n, lb_n, ba};
    end
    if (!(wl_n & wh_n) && idle_r)
      w_cnt <= w_cnt + 8'h01;
    idle_r <= wl_n & wh_n;
    // Lines toggle outside a read, so a late sample cannot meet stale data.
    rd_bus <= (re_n === 1'b0) ? {a_r[7:0] ^ 8'hA5, a_r[7:0]} : ~rd_bus;
  end
endmodule // etw_mem_model

// *** dv/etw_props.sv ***
`timescale 1ns/10ps
module etw_props
(
  input wire        clk,
  input wire        reset,
  input wire        fetch_req,
  input wire        busy,
  input wire [15:0] ad_oe,
  input wire        addr_le,
  input wire        write_low_strobe_n,
  input wire        write_high_strobe_n,
  input wire        upper_byte_select_n,
  input wire        lower_byte_select_n,
  input wire        byte_address_line
);
  wire st_n  = write_low_strobe_n & write_high_strobe_n;
  wire sel_n = upper_byte_select_n & lower_byte_select_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_idle_quiet: assert property (!busy |-> st_n && sel_n) else $error("strobe while idle");
  a_addr_quiet: assert property (addr_le |-> st_n && sel_n) else $error("strobe in address");
  a_one_strobe: assert property (write_low_strobe_n || write_high_strobe_n) else $error("two strobes");
  a_data_driven: assert property (!st_n |-> ad_oe[7:0] == 8'hFF) else $error("bus released");
  a_strobe_len: assert property ($fell(st_n) |-> !st_n [*4]) else $error("short strobe");
  a_busy_min: assert property ($rose(busy) |-> busy [*8]) else $error("short access");
  a_busy_max: assert property ($rose(busy) |-> ##[8:20] !busy) else $error("long access");
  a_fetch_gate: assert property ($rose(busy) |-> !$past(fetch_req)) else $error("start in fetch");
  a_ba_steady: assert property (!st_n && !$past(st_n) |-> $stable(byte_address_line)) else $error("ba moved");
  c_access: cover property ($rose(busy));
  c_low: cover property (!write_low_strobe_n);
  c_word: cover property (!write_high_strobe_n && !upper_byte_select_n && !lower_byte_select_n);
endmodule // etw_props
bind etw_write_port etw_props u_props
(
  .clk(clk), .reset(reset), .fetch_req(fetch_req), .busy(busy), .ad_oe(ad_oe), .addr_le(addr_le),
  .write_low_strobe_n(write_low_strobe_n), .write_high_strobe_n(write_high_strobe_n),
  .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
  .byte_address_line(byte_address_line)
);

// *** dv/etw_write_port_tb.sv ***
`timescale 1ns/10ps
module etw_write_port_tb;
  reg         clk, reset, reg_wr, reg_rd, twr, trd, fetch_req;
  reg  [3:0]  reg_addr;
  reg  [7:0]  reg_wdata, v, d, d2, c0;
  reg  [1:0]  ptr_op, o;
  reg  [20:0] q, pe;
  wire [7:0]  reg_rdata, w_cnt;
  wire [15:0] rd_bus, ad_out, ad_oe, w_data;
  wire [20:0] w_addr;
  wire [4:0]  addr_hi, w_kind;
  wire        busy, addr_le, wl_n, wh_n, ub_n, lb_n, ba, re_n;
  integer     error_cnt, checks, cyc, n, i, k;
  etw_write_port dut
  (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .table_write_instr(twr), .table_read_instr(trd), .ptr_op(ptr_op),
    .fetch_req(fetch_req), .rd_bus_in(rd_bus), .busy(busy), .ad_out(ad_out), .ad_oe(ad_oe),
    .addr_hi(addr_hi), .addr_le(addr_le), .write_low_strobe_n(wl_n), .write_high_strobe_n(wh_n),
    .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n), .byte_address_line(ba), .read_enable_n(re_n)
  );
  etw_mem_model u_mem
  (
    .clk(clk), .ad_out(ad_out), .addr_hi(addr_hi), .addr_le(addr_le), .wl_n(wl_n), .wh_n(wh_n), .ub_n(ub_n),
    .lb_n(lb_n), .ba(ba), .re_n(re_n), .rd_bus(rd_bus), .w_addr(w_addr), .w_data(w_data), .w_kind(w_kind),
    .w_cnt(w_cnt)
  );
  function [20:0] nptr(input [20:0] x, input [1:0] po);
    nptr = (po == 2'h1 || po == 2'h3) ? x + 21'h1 : (po == 2'h2) ? x - 21'h1 : x;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task rw(input [3:0] a, input [7:0] x);
  begin
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  end
  endtask
  task rr(input [3:0] a);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  end
  endtask
  task setp(input [20:0] x);
  begin
    rw(4'h1, x[7:0]);
    rw(4'h2, x[15:8]);
    rw(4'h3, {3'h0, x[20:16]});
  end
  endtask
  task op(input w, input [1:0] po, input [1:0] wt);
  begin
    twr <= w;
    trd <= !w;
    ptr_op <= po;
    n = 1;
    for (i = 0; i < 12 && busy !== 1'b1; i = i + 1)
      @(negedge clk);
    @(posedge clk);
    twr <= 1'b0;
    trd <= 1'b0;
    @(negedge clk);
    while (busy === 1'b1 && n < 30)
    begin
      n = n + 1;
      @(negedge clk);
    end
    chk(n, 8 + 4 * wt);
    @(posedge clk);
  end
  endtask
  task tw(input [7:0] mc, input [20:0] x, input [1:0] po, input [7:0] dd);
  begin
    rw(4'h4, mc);
    setp(x);
    rw(4'h0, dd);
    c0 = w_cnt;
    pe = (po == 2'h3) ? x + 21'h1 : x;
    op(1'b1, po, mc[1:0]);
    rr(4'h1);
    chk(v, nptr(x, po) & 21'hFF);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, twr, trd, fetch_req, ptr_op} = 0;
    {reg_addr, reg_wdata} = 0;
    {error_cnt, checks, cyc} = 0;
    k = $urandom(32'h1100c890);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rr(4'h4);
    chk(v, 8'h03);
    rr(4'hF);
    chk(v, 8'h00);
    rw(4'h0, 8'hC3);
    rr(4'h0);
    chk(v, 8'hC3);
    $display("reset test done");
    for (k = 0; k < 8; k = k + 1)
    begin
      q = $urandom & 21'h07FFFF;
      d = $urandom;
      o = $urandom;
      tw({6'h00, k[1:0]}, q, o, d);
      chk(w_cnt, c0 + 8'h01);
      chk(w_addr, pe);
      chk(w_data, {d, d});
      chk(w_kind[4:3], pe[0] ? 2'b01 : 2'b10);
    end
    tw(8'h80, $urandom & 21'h07FFFF, 2'h0, d);
    chk(w_kind[4:3], 2'b10);
    chk(w_data[7:0], d);
    $display("byte write test done");
    q = $urandom & 21'h07FFFE;
    d2 = $urandom;
    tw(8'h10, q, 2'h1, d);
    chk(w_cnt, c0);
    rr(4'h6);
    chk(v, d);
    rw(4'h0, d2);
    op(1'b1, 2'h0, 2'h0);
    chk(w_data, {d2, d});
    chk(w_kind, 5'b01001);
    chk(w_addr, q | 21'h1);
    for (k = 0; k < 2; k = k + 1)
    begin
      q = ($urandom & 21'h07FFFE) | {20'h0, k[0]};
      tw(8'h21, q, 2'h0, d);
      chk(w_data, {d, d});
      chk(w_kind, k[0] ? 5'b01011 : 5'b01100);
    end
    $display("word test done");
    setp(21'h100000 | ($urandom & 21'h00FFFF));
    c0 = w_cnt;
    twr <= 1'b1;
    repeat (8) @(posedge clk);
    twr <= 1'b0;
    rr(4'h5);
    chk(v[3], 1'b1);
    chk(w_cnt, c0);
    setp($urandom & 21'h07FFFF);
    fetch_req <= 1'b1;
    twr <= 1'b1;
    repeat (8) @(negedge clk) chk(busy, 1'b0);
    @(posedge clk);
    fetch_req <= 1'b0;
    op(1'b1, 2'h0, 2'h1);
    $display("refusal test done");
    q = ($urandom & 21'h07FFFE) | 21'h1;
    rw(4'h4, 8'h02);
    setp(q);
    op(1'b0, 2'h0, 2'h2);
    rr(4'h0);
    chk(v, q[7:0] ^ 8'hA5);
    $display("read test done");
    finish_test;
  end
endmodule // etw_write_port_tb

// *** hdl/etw_defs.vh ***
`ifndef ETW_DEFS_VH
`define ETW_DEFS_VH
// Register offsets on the plain register port (index = byte address).
`define ETW_ADDR_LATCH     4'h0
`define ETW_ADDR_PTR_LOW   4'h1
`define ETW_ADDR_PTR_HIGH  4'h2
`define ETW_ADDR_PTR_UPPER 4'h3
`define ETW_ADDR_MEMORY_CONTROL_REG    4'h4
`define ETW_ADDR_STATUS    4'h5
`define ETW_ADDR_HOLD      4'h6
// Memory control register fields.
`define ETW_WAIT_LSB       0
`define ETW_WM_LSB         4
`define ETW_BUS8_BIT       7
`define ETW_MEMORY_CONTROL_REG_RESET   8'h03
// Write mode field encodings.
`define ETW_WM_BYTE_WRITE  2'h0
`define ETW_WM_WORD_WRITE  2'h1
`define ETW_WM_BYTE_SELECT 2'h2
// Pointer update variants.
`define ETW_PTR_KEEP       2'h0
`define ETW_PTR_POST_INC   2'h1
`define ETW_PTR_POST_DEC   2'h2
`define ETW_PTR_PRE_INC    2'h3
// Pointer layout.
`define ETW_PTR_WIDTH      21
// Quarter phases of one instruction cycle.
`define ETW_QPHASES        2'h3
`define ETW_Q4             2'h3
// Configuration space base (upper pointer byte).
`define ETW_CFG_UPPER      5'h10
`endif

// *** hdl/etw_phase_gen.v ***
`timescale 1ns/10ps
// Quarter phase counter: an instruction cycle is four clocks unless hold parks it on the fourth phase.
module etw_phase_gen
(
  clk,
  reset,
  hold,
  phase,
  cycle_end
);
`include "etw_defs.vh"
  input        clk;
  input        reset;
  input        hold;
  output [1:0] phase;
  output       cycle_end;
  reg    [1:0] phase_r;

  // The counter parks on the fourth phase while a wait is held, so waits stretch at that phase.
  always @(posedge clk)
  begin
    if (reset)
      phase_r <= 2'h0;
    else if (!(hold && phase_r == `ETW_Q4))
      phase_r <= phase_r + 2'h1;
  end

  assign phase     = phase_r;
  assign cycle_end = (phase_r == `ETW_Q4) && !hold;
endmodule // etw_phase_gen

// *** hdl/etw_write_port.v ***
`timescale 1ns/10ps
module etw_write_port
(
  clk,
  reset,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  table_write_instr,
  table_read_instr,
  ptr_op,
  fetch_req,
  rd_bus_in,
  busy,
  ad_out,
  ad_oe,
  addr_hi,
  addr_le,
  write_low_strobe_n,
  write_high_strobe_n,
  upper_byte_select_n,
  lower_byte_select_n,
  byte_address_line,
  read_enable_n
);
`include "etw_defs.vh"
  parameter PW = `ETW_PTR_WIDTH;
  input             clk;
  input             reset;
  input      [3:0]  reg_addr;
  input      [7:0]  reg_wdata;
  input             reg_wr;
  input             reg_rd;
  output     [7:0]  reg_rdata;
  input             table_write_instr;
  input             table_read_instr;
  input      [1:0]  ptr_op;
  input             fetch_req;
  input      [15:0] rd_bus_in;
  output            busy;
  output     [15:0] ad_out;
  output     [15:0] ad_oe;
  output     [4:0]  addr_hi;
  output            addr_le;
  output            write_low_strobe_n;
  output            write_high_strobe_n;
  output            upper_byte_select_n;
  output            lower_byte_select_n;
  output            byte_address_line;
  output            read_enable_n;

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [7:0]    reg_rdata_r;
  reg [7:0]    table_latch_r;
  reg [7:0]    hold_latch_r;
  reg [7:0]    memory_control_reg_r;
  reg [PW-1:0] table_pointer_r;
  reg [1:0]    state_r;
  reg [3:0]    wait_cnt_r;
  reg          is_write_r;
  reg          post_inc_r;
  reg          post_dec_r;
  reg          cfg_refused_r;
  reg          busy_r;
  reg [15:0]   ad_out_r;
  reg [15:0]   ad_oe_r;
  reg [4:0]    addr_hi_r;
  reg          addr_le_r;
  reg          wrl_n_r;
  reg          wrh_n_r;
  reg          ub_n_r;
  reg          lb_n_r;
  reg          ba0_r;
  reg          rd_n_r;

  wire [1:0] phase;
  wire       cycle_end;
  wire       stretch;
  wire [1:0] wait_field = memory_control_reg_r[`ETW_WAIT_LSB+1:`ETW_WAIT_LSB];
  wire [1:0] write_mode_field = memory_control_reg_r[`ETW_WM_LSB+1:`ETW_WM_LSB];
  wire       bus8 = memory_control_reg_r[`ETW_BUS8_BIT];
  wire       start = (state_r == ST_IDLE) && (phase == `ETW_Q4) && !fetch_req
                     && (table_write_instr || table_read_instr);
  wire [PW-1:0] ptr_inc = table_pointer_r + {{(PW-1){1'b0}}, 1'b1};
  wire [PW-1:0] ptr_dec = table_pointer_r - {{(PW-1){1'b0}}, 1'b1};
  wire [PW-1:0] acc_ptr = (ptr_op == `ETW_PTR_PRE_INC) ? ptr_inc : table_pointer_r;
  wire          ptr0 = table_pointer_r[0];

  wire          word_mode = !bus8 && (write_mode_field == `ETW_WM_WORD_WRITE);
  wire          word_even = is_write_r && word_mode && !ptr0;
  wire          word_odd  = is_write_r && word_mode && ptr0;
  // A 16-bit read takes an odd byte from the high half of the bus.
  wire [7:0]    rd_byte   = (bus8 || !ptr0) ? rd_bus_in[7:0] : rd_bus_in[15:8];
  wire [15:0]   lane_byte;
  wire [15:0]   lane_oe;
  reg  [1:0]    lane_drive;
  reg           wrl_n_nxt;
  reg           wrh_n_nxt;
  reg           ub_n_nxt;
  reg           lb_n_nxt;
  genvar        g;

  // Only the data cycle of a table access is stretched; fetches never reach this state.
  assign stretch = (state_r == ST_DATA || state_r == ST_WAIT) && (wait_cnt_r != 4'h0);

  etw_phase_gen u_phase
  (
    .clk       (clk),
    .reset     (reset),
    .hold      (stretch),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // Data-cycle pin values, loaded into the output flops as the address cycle ends.
  always @*
  begin
    lane_drive = 2'b00;
    wrl_n_nxt  = 1'b1;
    wrh_n_nxt  = 1'b1;
    ub_n_nxt   = 1'b1;
    lb_n_nxt   = 1'b1;
    if (is_write_r)
    begin
      if (bus8)
      begin
        lane_drive = 2'b01;
        wrl_n_nxt  = 1'b0;
      end
      else
      begin
        case (write_mode_field)
          `ETW_WM_WORD_WRITE:
          begin
            // An even write only fills the holding latch, so the bus stays released.
            if (ptr0)
            begin
              lane_drive = 2'b11;
              wrh_n_nxt  = 1'b0;
              ub_n_nxt   = 1'b0;
              lb_n_nxt   = 1'b0;
            end
          end
          `ETW_WM_BYTE_SELECT:
          begin
            lane_drive = 2'b11;
            wrh_n_nxt  = 1'b0;
            ub_n_nxt   = !ptr0;
            lb_n_nxt   = ptr0;
          end
          default:
          begin
            lane_drive = 2'b11;
            wrh_n_nxt  = !ptr0;
            wrl_n_nxt  = ptr0;
          end
        endcase
      end
    end
  end

  // Both byte lanes come from one loop; only the low lane of an odd word write shows the holding latch.
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_lane
      wire lane_hold = word_odd && (g == 0);
      assign lane_byte[8*g+7:8*g] = lane_hold ? hold_latch_r : table_latch_r;
      assign lane_oe[8*g+7:8*g]   = {8{lane_drive[g]}};
    end
  endgenerate

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r    <= ST_IDLE;
      wait_cnt_r <= 4'h0;
      is_write_r <= 1'b0;
      post_inc_r <= 1'b0;
      post_dec_r <= 1'b0;
      cfg_refused_r <= 1'b0;
      busy_r     <= 1'b0;
      table_pointer_r <= {PW{1'b0}};
      table_latch_r   <= 8'h00;
      hold_latch_r    <= 8'h00;
      memory_control_reg_r <= `ETW_MEMORY_CONTROL_REG_RESET;
      reg_rdata_r <= 8'h00;
      ad_out_r  <= 16'h0000;
      ad_oe_r   <= 16'h0000;
      addr_hi_r <= 5'h00;
      addr_le_r <= 1'b0;
      wrl_n_r   <= 1'b1;
      wrh_n_r   <= 1'b1;
      ub_n_r    <= 1'b1;
      lb_n_r    <= 1'b1;
      ba0_r     <= 1'b0;
      rd_n_r    <= 1'b1;
    end
    else
    begin
      reg_rdata_r <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `ETW_ADDR_LATCH:     reg_rdata_r <= table_latch_r;
          `ETW_ADDR_PTR_LOW:   reg_rdata_r <= table_pointer_r[7:0];
          `ETW_ADDR_PTR_HIGH:  reg_rdata_r <= table_pointer_r[15:8];
          `ETW_ADDR_PTR_UPPER: reg_rdata_r <= {3'h0, table_pointer_r[PW-1:16]};
          `ETW_ADDR_MEMORY_CONTROL_REG:    reg_rdata_r <= memory_control_reg_r;
          `ETW_ADDR_STATUS:    reg_rdata_r <= {4'h0, cfg_refused_r, is_write_r, state_r != ST_IDLE, busy_r};
          `ETW_ADDR_HOLD:      reg_rdata_r <= hold_latch_r;
          default:             reg_rdata_r <= 8'h00;
        endcase
      end
      if (reg_wr)
      begin
        case (reg_addr)
          `ETW_ADDR_LATCH:     table_latch_r <= reg_wdata;
          `ETW_ADDR_PTR_LOW:   table_pointer_r[7:0] <= reg_wdata;
          `ETW_ADDR_PTR_HIGH:  table_pointer_r[15:8] <= reg_wdata;
          `ETW_ADDR_PTR_UPPER: table_pointer_r[PW-1:16] <= reg_wdata[4:0];
          `ETW_ADDR_MEMORY_CONTROL_REG:    memory_control_reg_r <= reg_wdata;
          default:             ;
        endcase
      end
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            // Configuration space writes are refused: a write there never reaches the bus, while a read there proceeds.
            if (table_write_instr && acc_ptr[PW-1:16] >= `ETW_CFG_UPPER)
              cfg_refused_r <= 1'b1;
            else
            begin
              state_r    <= ST_ADDR;
              busy_r     <= 1'b1;
              is_write_r <= table_write_instr;
              post_inc_r <= (ptr_op == `ETW_PTR_POST_INC);
              post_dec_r <= (ptr_op == `ETW_PTR_POST_DEC);
              if (ptr_op == `ETW_PTR_PRE_INC)
                table_pointer_r <= ptr_inc;
            end
          end
        end
        ST_ADDR:
        begin
          ad_out_r  <= table_pointer_r[15:0];
          ad_oe_r   <= 16'hFFFF;
          addr_hi_r <= table_pointer_r[PW-1:16];
          addr_le_r <= (phase != `ETW_Q4);
          if (cycle_end)
          begin
            // First instruction cycle carries the address; the second is the data cycle.
            state_r    <= ST_DATA;
            addr_le_r  <= 1'b0;
            // The wait field counts instruction cycles; the counter runs in clocks while parked.
            wait_cnt_r <= {wait_field, 2'b00};
            ba0_r      <= ptr0;
            ad_oe_r    <= lane_oe;
            if (is_write_r)
              ad_out_r <= lane_byte;
            wrl_n_r    <= wrl_n_nxt;
            wrh_n_r    <= wrh_n_nxt;
            ub_n_r     <= ub_n_nxt;
            lb_n_r     <= lb_n_nxt;
            rd_n_r     <= is_write_r;
            // Only an even word write loads the holding latch, so an unpaired odd write reuses stale data.
            if (word_even)
              hold_latch_r <= table_latch_r;
          end
        end
        ST_DATA, ST_WAIT:
        begin
          if (phase == `ETW_Q4 && wait_cnt_r != 4'h0)
          begin
            // Each extra cycle is added while parked on the fourth phase.
            state_r    <= ST_WAIT;
            wait_cnt_r <= wait_cnt_r - 4'h1;
          end
          if (cycle_end)
          begin
            // Strobes rise at the end of the final cycle, writing the location then.
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
            wrl_n_r <= 1'b1;
            wrh_n_r <= 1'b1;
            ub_n_r  <= 1'b1;
            lb_n_r  <= 1'b1;
            rd_n_r  <= 1'b1;
            ad_oe_r <= 16'h0000;
            if (!is_write_r)
              table_latch_r <= rd_byte;
            if (post_inc_r)
              table_pointer_r <= ptr_inc;
            else if (post_dec_r)
              table_pointer_r <= ptr_dec;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign reg_rdata           = reg_rdata_r;
  assign busy                = busy_r;
  assign ad_out              = ad_out_r;
  assign ad_oe               = ad_oe_r;
  assign addr_hi             = addr_hi_r;
  assign addr_le             = addr_le_r;
  assign write_low_strobe_n  = wrl_n_r;
  assign write_high_strobe_n = wrh_n_r;
  assign upper_byte_select_n = ub_n_r;
  assign lower_byte_select_n = lb_n_r;
  assign byte_address_line   = ba0_r;
  assign read_enable_n       = rd_n_r;
endmodule // etw_write_port
